// ---- src/hbw_device.sv ----
/*
 device end of the host bus write handshake: detects write cycles, drives
 wait_ack and hands each completed write to the core; a write arriving while one is pending replaces it.
 assumes bus inputs synchronous to i_clk and a static mode setting.
*/
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////
module hbw_device (
   input wire logic i_clk,
   input wire logic i_reset,
   hbw_if.device bus,
   input wire hbw_pkg::hbw_mode_e i_mode,
   input wire hbw_pkg::hbw_sig_e i_sig,
   input wire logic i_wait_ack_en,
   output logic o_wr_valid,
   output logic [hbw_pkg::ADDR_W-1:0] o_wr_addr,
   output logic [hbw_pkg::DATA_W-1:0] o_wr_data,
   output logic o_wr_byte,
   output logic o_busy
);
   typedef struct packed {
      logic strobe;
      logic pending;
      logic pend_byte;
      logic [hbw_pkg::CNT_W-1:0] cnt;
      logic wait_o;
      logic wait_oe_n;
      logic wr_valid;
      logic [hbw_pkg::ADDR_W-1:0] wr_addr;
      logic [hbw_pkg::DATA_W-1:0] wr_data;
      logic wr_byte;
      logic acked;
   } hbw_dev_s;

   hbw_dev_s st_r;
   hbw_dev_s st_nxt;
   logic strobe_now;
   logic start;
   logic stop;
   logic done;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      if (i_sig == hbw_pkg::HBW_SEPARATE) begin
         strobe_now = bus.cs & bus.wr;
      end else begin
         strobe_now = bus.cs & bus.transfer_strobe & ~bus.rd_wr;
      end
      start = strobe_now & ~st_r.strobe;
      stop = ~strobe_now & st_r.strobe;
      done = st_r.pending && (st_r.cnt == '0);
   end

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.strobe = strobe_now;
      st_nxt.wr_valid = 1'b0;
      // internal write countdown
      if (st_r.pending && st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
      if (done) begin
         st_nxt.pending = 1'b0;
         st_nxt.wr_valid = 1'b1;
         st_nxt.wr_byte = st_r.pend_byte;
      end
      // capture at strobe end for posted and legacy, at start for non-posted
      if ((i_mode == hbw_pkg::HBW_NONPOSTED) ? start : stop) begin
         st_nxt.wr_addr = bus.addr;
         st_nxt.wr_data = bus.data;
         st_nxt.wr_byte = bus.byte_mode;
      end
      if (i_mode == hbw_pkg::HBW_NONPOSTED && start) begin
         st_nxt.pending = 1'b1;
         st_nxt.pend_byte = bus.byte_mode;
         st_nxt.cnt = bus.byte_mode ? hbw_pkg::INT_WRITE8_CYC : hbw_pkg::INT_WRITE16_CYC;
         st_nxt.acked = 1'b0;
      end
      if (i_mode != hbw_pkg::HBW_NONPOSTED && stop) begin
         // posted write accepted; legacy writes complete the same way
         // legacy cannot stall, so a strobe end while pending restarts the count
         st_nxt.pending = 1'b1;
         st_nxt.pend_byte = bus.byte_mode;
         st_nxt.cnt = bus.byte_mode ? hbw_pkg::INT_WRITE8_CYC : hbw_pkg::INT_WRITE16_CYC;
         st_nxt.wr_addr = bus.addr;
         st_nxt.wr_data = bus.data;
      end
      if (done && i_mode == hbw_pkg::HBW_NONPOSTED) begin
         st_nxt.acked = 1'b1;
      end
      if (stop) begin
         st_nxt.acked = 1'b0;
      end
      // wait_ack level
      st_nxt.wait_oe_n = ~(i_wait_ack_en & bus.cs);
      case (i_mode)
         hbw_pkg::HBW_LEGACY: begin
            st_nxt.wait_o = 1'b0;
         end
         hbw_pkg::HBW_POSTED: begin
            // active while pending, and again right after a strobe ends
            st_nxt.wait_o = (st_nxt.pending & ~done) | stop;
            if (stop && !bus.cs) begin
               st_nxt.wait_oe_n = 1'b1;
            end
         end
         hbw_pkg::HBW_NONPOSTED: begin
            st_nxt.wait_o = strobe_now & ~st_nxt.acked & ~done;
         end
         default: begin
            st_nxt.wait_o = 1'b0;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
         st_r.wait_oe_n <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.wait_ack_o = st_r.wait_o;
   assign bus.wait_ack_oe_n = st_r.wait_oe_n;
   assign o_wr_valid = st_r.wr_valid;
   assign o_wr_addr = st_r.wr_addr;
   assign o_wr_data = st_r.wr_data;
   assign o_wr_byte = st_r.wr_byte;
   assign o_busy = st_r.pending;
endmodule

// ---- common/hbw_pkg.sv ----
/*
 the shared constants and types of the host bus write handshake: bus widths,
 modes, strobe styles and the timing figures turned into 25 MHz clock counts.
 assumes one 25 MHz clock shared by both ends.
*/
package hbw_pkg;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   // least times, rounded up to whole cycles
   localparam int unsigned T_STROBE_ACTIVE_NS = 32;
   localparam int unsigned T_STROBE_CYCLE_NS = 45;
   localparam int unsigned T_STROBE_GAP_NS = 13;
   localparam int unsigned STROBE_ACTIVE_CYC = (T_STROBE_ACTIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYCLE_CYC = (T_STROBE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_GAP_CYC = (T_STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // longest times, rounded down, never under one cycle
   localparam int unsigned T_WRITE8_NS = 200;
   localparam int unsigned T_WRITE16_NS = 280;
   localparam int unsigned WRITE8_CYC = T_WRITE8_NS / CLK_PERIOD_NS;
   localparam int unsigned WRITE16_CYC = T_WRITE16_NS / CLK_PERIOD_NS;
   localparam int unsigned T_WAIT_EDGE_NS = 10;
   localparam int unsigned WAIT_EDGE_CYC = (T_WAIT_EDGE_NS / CLK_PERIOD_NS) < 1 ? 1 : T_WAIT_EDGE_NS / CLK_PERIOD_NS;
   localparam int unsigned T_WAIT_OFF_NS = 9;
   localparam int unsigned WAIT_OFF_CYC = (T_WAIT_OFF_NS / CLK_PERIOD_NS) < 1 ? 1 : T_WAIT_OFF_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 4;
   // internal write duration in cycles; fits the documented worst case
   localparam logic [CNT_W-1:0] INT_WRITE8_CYC = 4'h3;
   localparam logic [CNT_W-1:0] INT_WRITE16_CYC = 4'h5;

   typedef enum logic [1:0] {HBW_LEGACY, HBW_POSTED, HBW_NONPOSTED} hbw_mode_e;
   typedef enum logic {HBW_SEPARATE, HBW_DIR_STROBE} hbw_sig_e;
endpackage

// ---- common/hbw_if.sv ----
/*
 the parallel host bus between host and device, write side.
 assumes both ends run on the same clock; wait_ack is resolved here.
*/
`timescale 1ns/100ps
interface hbw_if;
   logic cs;
   logic wr;
   logic rd;
   logic rd_wr;
   logic transfer_strobe;
   logic byte_mode;
   logic [hbw_pkg::ADDR_W-1:0] addr;
   logic [hbw_pkg::DATA_W-1:0] data;
   logic wait_ack_o;
   logic wait_ack_oe_n;
   logic wait_ack;
   // undriven wait_ack reads as inactive, like the board pull
   assign wait_ack = wait_ack_oe_n ? 1'b0 : wait_ack_o;
   modport device (input cs, wr, rd, rd_wr, transfer_strobe, byte_mode, addr, data,
      output wait_ack_o, wait_ack_oe_n);
   modport host (output cs, wr, rd, rd_wr, transfer_strobe, byte_mode, addr, data,
      input wait_ack);
endinterface

// ---- src/hbw_host.sv ----
/*
 host end of the host bus write handshake: runs one write per request,
 honouring strobe widths, gaps and the wait_ack handshake.
 assumes the device shares i_clk.
*/
`timescale 1ns/100ps
module hbw_host (
   input wire logic i_clk,
   input wire logic i_reset,
   hbw_if.host bus,
   input wire hbw_pkg::hbw_sig_e i_sig,
   input wire logic i_use_wait,
   input wire logic i_req,
   input wire logic [hbw_pkg::ADDR_W-1:0] i_addr,
   input wire logic [hbw_pkg::DATA_W-1:0] i_data,
   input wire logic i_byte,
   output logic o_ready,
   output logic o_done
);
   typedef enum logic [1:0] {HH_IDLE, HH_STROBE, HH_GAP} hbw_hst_e;
   typedef struct packed {
      hbw_hst_e state;
      logic [hbw_pkg::CNT_W-1:0] cnt;
      logic cs;
      logic strobe;
      logic is_byte;
      logic [hbw_pkg::ADDR_W-1:0] addr;
      logic [hbw_pkg::DATA_W-1:0] data;
      logic ready;
      logic done;
   } hbw_host_s;

   hbw_host_s st_r;
   hbw_host_s st_nxt;

   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
      case (st_r.state)
         HH_IDLE: begin
            if (i_req && st_r.ready) begin
               // cs rises with the strobe
               st_nxt.state = HH_STROBE;
               st_nxt.cs = 1'b1;
               st_nxt.strobe = 1'b1;
               st_nxt.addr = i_addr;
               st_nxt.data = i_data;
               st_nxt.is_byte = i_byte;
               st_nxt.ready = 1'b0;
               if (i_use_wait) begin
                  st_nxt.cnt = 4'(hbw_pkg::STROBE_CYCLE_CYC + hbw_pkg::WAIT_EDGE_CYC);
               end else begin
                  st_nxt.cnt = i_byte ? 4'(hbw_pkg::WRITE8_CYC) : 4'(hbw_pkg::WRITE16_CYC);
               end
            end
         end
         HH_STROBE: begin
            // hold until time met and wait_ack inactive
            if (st_r.cnt <= 4'h1 && !(i_use_wait && bus.wait_ack)) begin
               st_nxt.state = HH_GAP;
               st_nxt.cs = 1'b0;
               st_nxt.strobe = 1'b0;
               st_nxt.cnt = 4'(hbw_pkg::STROBE_GAP_CYC);
               st_nxt.done = 1'b1;
            end
         end
         HH_GAP: begin
            if (st_r.cnt <= 4'h1) begin
               st_nxt.state = HH_IDLE;
               st_nxt.ready = 1'b1;
            end
         end
         default: begin
            st_nxt.state = HH_IDLE;
         end
      endcase
   end

   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         st_r <= '0;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign bus.cs = st_r.cs;
   assign bus.wr = st_r.strobe & (i_sig == hbw_pkg::HBW_SEPARATE);
   assign bus.rd = 1'b0;
   assign bus.transfer_strobe = st_r.strobe & (i_sig == hbw_pkg::HBW_DIR_STROBE);
   assign bus.rd_wr = 1'b0;
   assign bus.byte_mode = st_r.is_byte;
   assign bus.addr = st_r.addr;
   assign bus.data = st_r.data;
   assign o_ready = st_r.ready;
   assign o_done = st_r.done;
endmodule

// ---- tb/hbw_properties.sv ----
/*
 checks on the host bus write handshake.
 assumes the signals of one hbw_if and the device mode inputs.
*/
`timescale 1ns/100ps
module hbw_properties (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic cs,
   input wire logic wr,
   input wire logic rd_wr,
   input wire logic transfer_strobe,
   input wire logic byte_mode,
   input wire logic wait_ack_o,
   input wire logic wait_ack_oe_n,
   input wire hbw_pkg::hbw_mode_e i_mode,
   input wire hbw_pkg::hbw_sig_e i_sig,
   input wire logic i_wait_ack_en
);
   localparam int W8 = hbw_pkg::WRITE8_CYC;
   localparam int W16 = hbw_pkg::WRITE16_CYC;
   wire logic stb;
   wire logic np;
   wire logic pw;
   wire logic raw_stb;
   wire logic ack;
   assign raw_stb = (i_sig == hbw_pkg::HBW_SEPARATE) ? wr : transfer_strobe;
   assign ack = ~wait_ack_oe_n & wait_ack_o;
   assign stb = cs & ((i_sig == hbw_pkg::HBW_SEPARATE) ? wr : (transfer_strobe & ~rd_wr));
   assign np = i_mode == hbw_pkg::HBW_NONPOSTED;
   assign pw = i_mode == hbw_pkg::HBW_POSTED;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   //////////////////////////////////////////////////////////////////////////////
   ack_driven_a: assert property (cs && i_wait_ack_en |=> !wait_ack_oe_n)
      else $error("wait_ack not driven");
   ack_released_a: assert property (!cs |=> wait_ack_oe_n)
      else $error("wait_ack not released");
   legacy_no_wait_a: assert property (i_mode == hbw_pkg::HBW_LEGACY |-> !wait_ack_o)
      else $error("legacy wait shown");
   np_wait_on_a: assert property ($rose(stb) && np |=> wait_ack_o)
      else $error("nonposted wait late");
   np_done8_a: assert property ($rose(stb) && np && byte_mode |-> ##[1:W8] !wait_ack_o)
      else $error("8-bit write slow");
   np_done16_a: assert property ($rose(stb) && np && !byte_mode |-> ##[1:W16] !wait_ack_o)
      else $error("16-bit write slow");
   posted_rearm_a: assert property ($fell(stb) && pw |=> wait_ack_o)
      else $error("posted wait late");
   posted_clr8_a: assert property ($fell(stb) && pw && $past(byte_mode) |-> ##[1:W8] !wait_ack_o)
      else $error("8-bit pending slow");
   posted_clr16_a: assert property ($fell(stb) && pw && !$past(byte_mode) |-> ##[1:W16] !wait_ack_o)
      else $error("16-bit pending slow");
   cs_steady_a: assert property (raw_stb && cs |=> cs || !raw_stb)
      else $error("cs changed in strobe");
   strobe_width_a: assert property ($rose(stb) |=> stb)
      else $error("strobe too short");
   strobe_gap_a: assert property ($fell(stb) |=> !stb)
      else $error("strobe gap short");
   strobe_hold_a: assert property (stb && ack |=> stb)
      else $error("strobe dropped early");
   nowait_hold16_a: assert property ($rose(stb) && !i_wait_ack_en && !byte_mode |=> stb [*6])
      else $error("unpaced strobe short");
   cover property ($rose(stb) && np);
   cover property ($fell(stb) && pw);
   cover property ($rose(stb) && i_mode == hbw_pkg::HBW_LEGACY);
endmodule

// ---- tb/hbw_tb.sv ----
/*
 self-checking bench: host and device joined by one hbw_if.
 assumes the package constants and the hand-over timing.
*/
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module hbw_tb;
   logic i_clk;
   logic i_reset;
   hbw_pkg::hbw_mode_e mode;
   hbw_pkg::hbw_sig_e sig;
   logic wait_en;
   logic use_wait;
   logic req;
   logic [hbw_pkg::ADDR_W-1:0] addr;
   logic [hbw_pkg::DATA_W-1:0] data;
   logic byte_sel;
   logic ready;
   logic done;
   logic wr_valid;
   logic [hbw_pkg::ADDR_W-1:0] wr_addr;
   logic [hbw_pkg::DATA_W-1:0] wr_data;
   logic wr_byte;
   logic busy;
   logic saw_wait;
   logic saw_drive;
   logic [32:0] got_q[$];
   int fail_count;
   int checked;
   hbw_if bus ();
   hbw_device u_hbw_device (.i_clk(i_clk), .i_reset(i_reset), .bus(bus), .i_mode(mode), .i_sig(sig),
      .i_wait_ack_en(wait_en), .o_wr_valid(wr_valid), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .o_wr_byte(wr_byte), .o_busy(busy));
   hbw_host u_hbw_host (.i_clk(i_clk), .i_reset(i_reset), .bus(bus), .i_sig(sig), .i_use_wait(use_wait),
      .i_req(req), .i_addr(addr), .i_data(data), .i_byte(byte_sel), .o_ready(ready), .o_done(done));
   hbw_properties u_hbw_properties (.i_clk(i_clk), .i_reset(i_reset), .cs(bus.cs), .wr(bus.wr),
      .rd_wr(bus.rd_wr), .transfer_strobe(bus.transfer_strobe), .byte_mode(bus.byte_mode),
      .wait_ack_o(bus.wait_ack_o), .wait_ack_oe_n(bus.wait_ack_oe_n), .i_mode(mode), .i_sig(sig),
      .i_wait_ack_en(wait_en));
   //////////////////////////////////////////////////////////////////////////////
   always @(posedge i_clk) begin
      if (wr_valid) got_q.push_back({wr_byte, wr_addr, wr_data});
      if (bus.wait_ack) saw_wait = 1'b1;
      if (!bus.wait_ack_oe_n) saw_drive = 1'b1;
   end
   task automatic setup(input hbw_pkg::hbw_mode_e m, input hbw_pkg::hbw_sig_e s, input logic en);
      repeat (4) @(negedge i_clk);
      mode = m;
      sig = s;
      wait_en = en;
      use_wait = en;
      @(negedge i_clk);
      saw_wait = 1'b0;
      saw_drive = 1'b0;
   endtask
   task automatic send(input logic [15:0] a, input logic [15:0] d, input logic b);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      req = 1'b1;
      addr = a;
      data = d;
      byte_sel = b;
      @(negedge i_clk);
      req = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      `CHK("strobe end", 1'b1, done)
   endtask
   task automatic expect_wr(input logic [32:0] w);
      logic [32:0] g;
      int n;
      n = 0;
      while (got_q.size() == 0 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      g = (got_q.size() > 0) ? got_q.pop_front() : 33'h0;
      `CHK("write", w, g)
   endtask
   //////////////////////////////////////////////////////////////////////////////
   task automatic legacy_write();
      setup(hbw_pkg::HBW_LEGACY, hbw_pkg::HBW_SEPARATE, 1'b1);
      send(16'h1234, 16'hA5C3, 1'b0);
      expect_wr({1'b0, 16'h1234, 16'hA5C3});
      `CHK("legacy busy", 1'b0, busy)
      `CHK("legacy wait", 1'b0, saw_wait)
      `CHK("legacy drive", 1'b1, saw_drive)
   endtask
   task automatic posted_pair();
      setup(hbw_pkg::HBW_POSTED, hbw_pkg::HBW_DIR_STROBE, 1'b1);
      send(16'h0102, 16'h00F1, 1'b1);
      send(16'h0204, 16'hBEEF, 1'b0);
      @(negedge i_clk);
      `CHK("posted busy", 1'b1, busy)
      expect_wr({1'b1, 16'h0102, 16'h00F1});
      expect_wr({1'b0, 16'h0204, 16'hBEEF});
      `CHK("posted wait", 1'b1, saw_wait)
   endtask
   task automatic nonposted_both();
      for (int b = 0; b < 2; b++) begin
         setup(hbw_pkg::HBW_NONPOSTED, hbw_pkg::HBW_SEPARATE, 1'b1);
         send(16'h3000 + b[15:0], 16'hC0DE, b[0]);
         expect_wr({b[0], 16'h3000 + b[15:0], 16'hC0DE});
         `CHK("nonposted wait", 1'b1, saw_wait)
      end
   endtask
   task automatic no_wait_write();
      setup(hbw_pkg::HBW_NONPOSTED, hbw_pkg::HBW_DIR_STROBE, 1'b0);
      send(16'h4AB0, 16'h5A5A, 1'b0);
      expect_wr({1'b0, 16'h4AB0, 16'h5A5A});
      `CHK("undriven ack", 1'b0, saw_drive)
   endtask
   task automatic complete_run();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (3000) @(posedge i_clk);
      fail_count++;
      complete_run();
   end
   initial begin
      i_reset = 1'b1;
      mode = hbw_pkg::HBW_LEGACY;
      sig = hbw_pkg::HBW_SEPARATE;
      {wait_en, use_wait, req, byte_sel, saw_wait, saw_drive} = '0;
      addr = '0;
      data = '0;
      repeat (3) @(negedge i_clk);
      i_reset = 1'b0;
      legacy_write();
      posted_pair();
      nonposted_both();
      no_wait_write();
      complete_run();
   end
endmodule
